// ---- shared/regi2c_defines.vh ----
// constants for the regulator i2c control port
`ifndef REGI2C_DEFINES_VH
`define REGI2C_DEFINES_VH
`define REGI2C_ADDR_BASE   7'h61
`define REGI2C_IDX_REF     8'h00
`define REGI2C_IDX_CTL1    8'h01
`define REGI2C_IDX_CTL2    8'h02
`define REGI2C_IDX_CUR     8'h03
`define REGI2C_IDX_VOLT    8'h04
`define REGI2C_IDX_ID      8'h05
`define REGI2C_IDX_STAT    8'h06
`define REGI2C_RST_REF     8'h1E
`define REGI2C_RST_CTL1    8'hA6
`define REGI2C_RST_CTL2    8'hC0
`define REGI2C_ID_VALUE    8'h5A
`define REGI2C_CTL1_ON     7
`define REGI2C_CTL1_GO     6
`define REGI2C_CTL1_RETRY  2
`define REGI2C_CTL1_HICCUP 1
`define REGI2C_CTL1_MODE   0
`endif

// ---- design/regi2c_port.v ----
// i2c slave register port of the regulator
`timescale 1ns/1ps
`default_nettype none
`include "regi2c_defines.vh"
module regi2c_port
#(
   parameter [7:0] ID_VALUE = `REGI2C_ID_VALUE // arbitrary identity value
)
(
   // clock and reset
   input  wire       clk_i,
   input  wire       resetn_i,
   // i2c pins
   input  wire       scl_i,
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe_n_o,
   // strap and supervision
   input  wire [1:0] address_strap_pin_i,
   input  wire       enable_pin_i,
   input  wire       input_supply_ok_i,
   input  wire       rail_ok_i,
   input  wire       soft_start_done_i,
   input  wire       thermal_shutdown_i,
   input  wire       temp_warn_i,
   input  wire       overcurrent_flag_i,
   input  wire       overcurrent_latch_i,
   input  wire       output_overvoltage_i,
   input  wire       input_overvoltage_i,
   input  wire       power_good_i,
   input  wire       transition_done_i,
   // telemetry
   input  wire [7:0] load_current_i,
   input  wire [7:0] output_voltage_i,
   // converter controls
   output reg  [6:0] reference_code_o,
   output reg  [2:0] slew_rate_o,
   output reg        light_load_mode_o,
   output reg        overcurrent_hiccup_bit_o,
   output reg  [7:0] control_two_o,
   output reg        switching_on_o,
   output reg        dynamic_regulation_o,
   output reg        shutdown_o
);
// ---------------------------------------------------
// synchronisers
// ---------------------------------------------------
reg  [1:0]  scl_s;
reg  [1:0]  sda_s;
reg         scl_d;
reg         sda_d;
reg  [13:0] pin_s0;
reg  [13:0] pin_s1;
reg  [1:0]  strap;
always @(posedge clk_i)
begin
   scl_s    <= {scl_s[0], scl_i};
   sda_s    <= {sda_s[0], sda_i};
   scl_d    <= scl_s[1];
   sda_d    <= sda_s[1];
   pin_s0   <= {enable_pin_i, input_supply_ok_i, rail_ok_i,
                soft_start_done_i, thermal_shutdown_i, temp_warn_i,
                overcurrent_flag_i, overcurrent_latch_i,
                output_overvoltage_i, input_overvoltage_i, power_good_i,
                transition_done_i, address_strap_pin_i};
   pin_s1   <= pin_s0;
end
wire       en_s, sup_s, rail_s, ssd_s, hot_s, warn_s, ocf_s;
wire       ocl_s, ovo_s, ovi_s, pg_s, tdone_s;
wire [1:0] strap_s1;
assign {en_s, sup_s, rail_s, ssd_s, hot_s, warn_s, ocf_s, ocl_s, ovo_s,
        ovi_s, pg_s, tdone_s, strap_s1} = pin_s1;
wire scl_rise = scl_s[1] & ~scl_d;
wire scl_fall = ~scl_s[1] & scl_d;
wire start_ev = scl_s[1] & scl_d & sda_d & ~sda_s[1];
wire stop_ev  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
// ---------------------------------------------------
// shutdown and protection
// ---------------------------------------------------
reg  ov_latch;
wire port_ok = en_s & sup_s & rail_s;
wire ov_check = en_s & sup_s;
wire down_any = ~port_ok | hot_s | ov_latch | ocl_s;
wire serving = ~down_any & ssd_s;
reg  [7:0] reg_ref;
reg  [7:0] reg_ctl1;
reg  [7:0] reg_ctl2;
always @(posedge clk_i)
begin
   if (!resetn_i || !ov_check)
   begin
      ov_latch             <= 1'b0;
      dynamic_regulation_o <= 1'b0;
   end
   else
   begin
      dynamic_regulation_o <= ovo_s
                            & reg_ctl1[`REGI2C_CTL1_RETRY];
      if (ovo_s & ovi_s
          & ~reg_ctl1[`REGI2C_CTL1_RETRY])
         ov_latch <= 1'b1;
   end
end
always @(posedge clk_i)
begin
   if (!resetn_i)
   begin
      shutdown_o     <= 1'b1;
      switching_on_o <= 1'b0;
   end
   else
   begin
      shutdown_o     <= down_any;
      switching_on_o <= ~down_any & reg_ctl1[`REGI2C_CTL1_ON];
   end
end
// ---------------------------------------------------
// i2c slave engine
// ---------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_AACK = 3'd2;
localparam ST_WDAT = 3'd3;
localparam ST_WACK = 3'd4;
localparam ST_RDAT = 3'd5;
localparam ST_RACK = 3'd6;
reg  [2:0] state;
reg  [3:0] bit_cnt;
reg  [7:0] shift;
reg        rw;
reg        have_index;
reg  [7:0] index;
reg        drive_low;
reg        wr_pulse;
reg  [7:0] wr_data;
wire [6:0] my_addr = `REGI2C_ADDR_BASE | {4'h0, strap, 1'b0};
reg  [7:0] rd_mux;
always @*
begin
   case (index)
      `REGI2C_IDX_REF:  rd_mux = reg_ref;
      `REGI2C_IDX_CTL1: rd_mux = reg_ctl1;
      `REGI2C_IDX_CTL2: rd_mux = reg_ctl2;
      `REGI2C_IDX_CUR:  rd_mux = load_current_i;
      `REGI2C_IDX_VOLT: rd_mux = output_voltage_i;
      `REGI2C_IDX_ID:   rd_mux = ID_VALUE;
      `REGI2C_IDX_STAT: rd_mux = {4'h0, ocf_s, warn_s,
                                  hot_s, pg_s};
      default:          rd_mux = 8'h00;
   endcase
end
always @(posedge clk_i)
begin
   if (!resetn_i || !serving)
   begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      rw         <= 1'b0;
      have_index <= 1'b0;
      index      <= 8'h00;
      drive_low  <= 1'b0;
      wr_pulse   <= 1'b0;
      wr_data    <= 8'h00;
      strap      <= 2'b00;
   end
   else
   begin
      wr_pulse <= 1'b0;
      strap    <= strap_s1;
      if (start_ev)
      begin
         state      <= ST_ADDR;
         bit_cnt    <= 4'h0;
         have_index <= 1'b0;
         drive_low  <= 1'b0;
      end
      else if (stop_ev)
      begin
         state     <= ST_IDLE;
         drive_low <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               drive_low <= 1'b0;
            ST_ADDR, ST_WDAT:
            begin
               if (scl_rise)
               begin
                  shift   <= {shift[6:0], sda_s[1]};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (scl_fall && bit_cnt == 4'h8)
               begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR)
                  begin
                     if (shift[7:1] == my_addr)
                     begin
                        rw        <= shift[0];
                        drive_low <= 1'b1;
                        state     <= ST_AACK;
                     end
                     else
                        state <= ST_IDLE;
                  end
                  else
                  begin
                     drive_low <= 1'b1;
                     state     <= ST_WACK;
                     if (!have_index)
                     begin
                        index      <= shift;
                        have_index <= 1'b1;
                     end
                     else
                     begin
                        wr_pulse <= 1'b1;
                        wr_data  <= shift;
                        index    <= index + 8'h01;
                     end
                  end
               end
            end
            ST_AACK, ST_WACK:
               if (scl_fall)
               begin
                  if (state == ST_AACK && rw)
                  begin
                     shift     <= {rd_mux[6:0], 1'b0};
                     drive_low <= ~rd_mux[7];
                     index     <= index + 8'h01;
                     bit_cnt   <= 4'h1;
                     state     <= ST_RDAT;
                  end
                  else
                  begin
                     drive_low <= 1'b0;
                     state     <= ST_WDAT;
                  end
               end
            ST_RDAT:
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     drive_low <= 1'b0;
                     bit_cnt   <= 4'h0;
                     state     <= ST_RACK;
                  end
                  else
                  begin
                     drive_low <= ~shift[7];
                     shift     <= {shift[6:0], 1'b0};
                     bit_cnt   <= bit_cnt + 4'h1;
                  end
               end
            ST_RACK:
            begin
               if (scl_rise)
                  rw <= ~sda_s[1];
               if (scl_fall)
               begin
                  if (rw)
                  begin
                     index     <= index + 8'h01;
                     shift     <= {rd_mux[6:0], 1'b0};
                     drive_low <= ~rd_mux[7];
                     bit_cnt   <= 4'h1;
                     state     <= ST_RDAT;
                  end
                  else
                     state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
end
assign sda_o      = 1'b0;
assign sda_oe_n_o = ~drive_low;
// ---------------------------------------------------
// register file
// ---------------------------------------------------
always @(posedge clk_i)
begin
   if (!resetn_i || !port_ok)
   begin
      reg_ref  <= `REGI2C_RST_REF;
      reg_ctl1 <= `REGI2C_RST_CTL1;
      reg_ctl2 <= `REGI2C_RST_CTL2;
   end
   else
   begin
      if (tdone_s)
         reg_ctl1[`REGI2C_CTL1_GO] <= 1'b0;
      if (wr_pulse)
      begin
         case (index - 8'h01)
            `REGI2C_IDX_REF:
               if (reg_ctl1[`REGI2C_CTL1_GO])
                  reg_ref <= {1'b0, wr_data[6:0]};
            `REGI2C_IDX_CTL1:
               reg_ctl1 <= wr_data;
            `REGI2C_IDX_CTL2:
               reg_ctl2 <= wr_data;
            default:
               reg_ref <= reg_ref;
         endcase
      end
   end
end
always @(posedge clk_i)
begin
   if (!resetn_i)
   begin
      reference_code_o         <= 7'h1E;
      slew_rate_o              <= 3'h4;
      light_load_mode_o        <= 1'b0;
      overcurrent_hiccup_bit_o <= 1'b1;
      control_two_o            <= `REGI2C_RST_CTL2;
   end
   else
   begin
      reference_code_o         <= reg_ref[6:0];
      slew_rate_o              <= reg_ctl1[5:3];
      light_load_mode_o        <= reg_ctl1[`REGI2C_CTL1_MODE]
                                | reg_ctl1[`REGI2C_CTL1_GO];
      overcurrent_hiccup_bit_o <= reg_ctl1[`REGI2C_CTL1_HICCUP];
      control_two_o            <= reg_ctl2;
   end
end
endmodule
`default_nettype wire

// ---- bench/regi2c_port_checker.sv ----
// assertions on the regulator i2c port pins
`timescale 1ns/1ps
`default_nettype none
module regi2c_chk
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // i2c pins
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   // supervision
   input wire logic enable_pin_i,
   input wire logic soft_start_done_i,
   input wire logic thermal_shutdown_i,
   input wire logic switching_on_o,
   input wire logic shutdown_o
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_high; scl_i[*6]; endsequence
   sequence s_down; shutdown_o[*2]; endsequence
   property p_hold; s_high |-> $stable(sda_oe_n_o); endproperty
   property p_edge; $changed(sda_oe_n_o) |-> !scl_i; endproperty
   property p_low; !sda_oe_n_o |-> !sda_o && !shutdown_o; endproperty
   property p_ack; (scl_i && !sda_oe_n_o) |=> !sda_oe_n_o; endproperty
   property p_soft; (!soft_start_done_i)[*4] |-> sda_oe_n_o; endproperty
   property p_off; s_down |-> sda_oe_n_o; endproperty
   property p_down;
      (!enable_pin_i || thermal_shutdown_i) |-> ##[1:6] shutdown_o;
   endproperty
   property p_sw; switching_on_o |-> !shutdown_o; endproperty
   a_hold: assert property (p_hold)
      else $error("sda drive moved while scl high");
   a_edge: assert property (p_edge)
      else $error("sda drive changed with scl high");
   a_low: assert property (p_low)
      else $error("sda driven high or while shut down");
   a_ack: assert property (p_ack)
      else $error("low drive released during scl high");
   a_soft: assert property (p_soft)
      else $error("sda driven before soft start done");
   a_off: assert property (p_off)
      else $error("sda driven while shut down");
   a_down: assert property (p_down)
      else $error("no shutdown after fault");
   a_sw: assert property (p_sw)
      else $error("switching while shut down");
endmodule
bind regi2c_port regi2c_chk u_chk
(
   .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .enable_pin_i(enable_pin_i),
   .soft_start_done_i(soft_start_done_i),
   .thermal_shutdown_i(thermal_shutdown_i),
   .switching_on_o(switching_on_o), .shutdown_o(shutdown_o)
);
`default_nettype wire

// ---- bench/regi2c_master.sv ----
// i2c bus master model for the port
`timescale 1ns/1ps
`default_nettype none
module regi2c_master
(
   // clock
   input  wire logic clk_i,
   // bus
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_o
);
   logic r;
   initial
   begin
      scl_o = 1;
      sda_o = 1;
   end
   // ----------------------------------------
   // bus phases of 20 ns or 40 ns, 80 ns per bit
   // ----------------------------------------
   task q(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task up(logic b);
      q(4);
      sda_o = b;
      q(4);
      scl_o = 1;
      q(8);
   endtask
   task xb(logic b, output logic v);
      up(b);
      v = sda_i;
      scl_o = 0;
   endtask
   task start();
      up(1);
      sda_o = 0;
      q(8);
      scl_o = 0;
   endtask
   task stop();
      up(0);
      sda_o = 1;
      q(940);
   endtask
   task wbyte(logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) xb(d[i], r);
      xb(1, r);
      ack = !r;
   endtask
   task rbyte(logic nak, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) xb(1, d[i]);
      xb(nak, r);
   endtask
endmodule
`default_nettype wire

// ---- bench/regi2c_port_tb_top.sv ----
// self-checking bench for the regulator i2c port
`timescale 1ns/1ps
`default_nettype none
module regi2c_port_tb_top;
   localparam logic [7:0] ID = 8'hC3; // arbitrary identity value
   logic       clk_i, resetn_i, en, sup, rail, ssd, hot, warn;
   logic       ocf, ocl, ovo, ovi, good, tdone, k;
   logic [1:0] strap;
   logic [7:0] cur, volt, d;
   logic [7:0] rg [0:2];
   int         err_total, check_count, i, s, a;
   wire        scl, sda_m, sda_o, oe_n, sw_on, dyn, shut, llm, hic;
   wire  [6:0] code;
   wire  [2:0] slew;
   wire  [7:0] ctl2;
   wire        sda = sda_m & (oe_n | sda_o);
   wire  [6:0] adr = {4'hC, strap, 1'h1};
   regi2c_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
   regi2c_port #(.ID_VALUE(ID)) dut
   (
      .clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(oe_n), .address_strap_pin_i(strap),
      .enable_pin_i(en), .input_supply_ok_i(sup), .rail_ok_i(rail),
      .soft_start_done_i(ssd), .thermal_shutdown_i(hot),
      .temp_warn_i(warn), .overcurrent_flag_i(ocf),
      .overcurrent_latch_i(ocl), .output_overvoltage_i(ovo),
      .input_overvoltage_i(ovi), .power_good_i(good),
      .transition_done_i(tdone), .load_current_i(cur),
      .output_voltage_i(volt), .reference_code_o(code),
      .slew_rate_o(slew), .light_load_mode_o(llm),
      .overcurrent_hiccup_bit_o(hic), .control_two_o(ctl2),
      .switching_on_o(sw_on), .dynamic_regulation_o(dyn), .shutdown_o(shut)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task cyc(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task deflt();
      rg[0] = 8'h1E;
      rg[1] = 8'hA6;
      rg[2] = 8'hC0;
   endtask
   task cmp8(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task cmp1(string n, logic e, logic g);
      cmp8(n, {7'h0, e}, {7'h0, g});
   endtask
   task wr(logic [7:0] x, logic [7:0] v);
      m.start();
      m.wbyte({adr, 1'h0}, k);
      m.wbyte(x, k);
      m.wbyte(v, k);
      cmp1("ack", 1'h1, k);
      m.stop();
   endtask
   task rd(logic [7:0] x, logic [7:0] e);
      m.start();
      m.wbyte({adr, 1'h0}, k);
      m.wbyte(x, k);
      m.start();
      m.wbyte({adr, 1'h1}, k);
      cmp1("rack", 1'h1, k);
      m.rbyte(1'h1, d);
      m.stop();
      cmp8("reg", e, d);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk_i = 0;
      forever #2.5 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      {resetn_i, hot, warn, ocf, ocl, ovo, ovi, good, tdone} = 9'h0;
      {en, sup, rail, ssd} = 4'hF;
      {strap, cur, volt} = 18'h0;
      err_total = 0;
      check_count = 0;
      deflt();
      cyc(8);
      resetn_i = 1;
      d = $urandom(79531);
      {cur, volt} = 16'($urandom);
      {ocf, warn, good} = 3'($urandom);
      cyc(4);
      for (i = 0; i < 3; i++) rd(i[7:0], rg[i]);
      rd(8'h03, cur);
      rd(8'h04, volt);
      rd(8'h05, ID);
      rd(8'h06, {4'h0, ocf, warn, 1'h0, good});
      m.start();
      m.wbyte({adr, 1'h0}, k);
      m.wbyte(8'h04, k);
      m.start();
      m.wbyte({adr, 1'h1}, k);
      m.rbyte(1'h0, d);
      cmp8("burst", volt, d);
      m.rbyte(1'h1, d);
      m.stop();
      cmp8("burst", ID, d);
      wr(8'h03, ~cur);
      rd(8'h03, cur);
      $display("test read map done");
      wr(8'h00, 8'h55);
      rd(8'h00, rg[0]);
      rg[1] = 8'($urandom) | 8'h40;
      wr(8'h01, rg[1]);
      rg[0] = 8'($urandom) & 8'h7F;
      wr(8'h00, rg[0]);
      cmp8("code", rg[0], {1'h0, code});
      cmp8("slew", {5'h0, rg[1][5:3]}, {5'h0, slew});
      cmp1("mode", 1'h1, llm);
      cmp1("hiccup", rg[1][1], hic);
      cmp1("on", rg[1][7], sw_on);
      ovo = 1;
      cyc(8);
      cmp1("dynreg", rg[1][2], dyn);
      ovo = 0;
      tdone = 1;
      cyc(1);
      tdone = 0;
      rg[1][6] = 0;
      rd(8'h01, rg[1]);
      cmp1("mode", rg[1][0], llm);
      rg[2] = 8'($urandom);
      wr(8'h02, rg[2]);
      cmp8("ctl2", rg[2], ctl2);
      rd(8'h02, rg[2]);
      $display("test control done");
      for (s = 0; s < 4; s++)
         for (a = 0; a < 4; a++)
         begin
            strap = s[1:0];
            cyc(4);
            m.start();
            m.wbyte({4'hC, a[1:0], 2'h2}, k);
            m.wbyte(8'h01, k);
            m.stop();
            cmp1("select", s == a, k);
         end
      $display("test address done");
      for (i = 0; i < 4; i++)
      begin
         {en, sup, rail, hot} = 4'hE ^ (4'h8 >> i);
         for (a = 0; a < 20 && shut !== 1'h1; a++) cyc(1);
         if (a == 20)
         begin
            err_total++;
            summarize();
         end
         cmp1("switch", 1'h0, sw_on);
         {en, sup, rail, hot} = 4'hE;
         cyc(20);
         cmp1("shut", 1'h0, shut);
         if (i < 3) deflt();
         rd(8'h00, rg[0]);
         rd(8'h01, rg[1]);
      end
      $display("test shutdown done");
      wr(8'h01, 8'hA2);
      {ovo, ovi} = 2'h3;
      for (a = 0; a < 20 && shut !== 1'h1; a++) cyc(1);
      {ovo, ovi} = 2'h0;
      cyc(20);
      cmp1("latch", 1'h1, shut);
      en = 0;
      cyc(8);
      en = 1;
      cyc(20);
      cmp1("unlatch", 1'h0, shut);
      deflt();
      rd(8'h01, rg[1]);
      $display("test latch done");
      ssd = 0;
      cyc(4);
      m.start();
      m.wbyte({adr, 1'h0}, k);
      m.stop();
      cmp1("busy", 1'h0, k);
      ssd = 1;
      cyc(8);
      rd(8'h02, rg[2]);
      $display("test soft start done");
      summarize();
   end
endmodule
`default_nettype wire
